// >>> rtl/fpi_pkg.sv
// package: constants for the front panel interface
package fpi_pkg;
  // function decoder codes on address bits 8 to 10
  localparam logic [2:0] FPI_SEL_DIGIT1 = 3'h0;
  localparam logic [2:0] FPI_SEL_DIGIT2 = 3'h1;
  localparam logic [2:0] FPI_SEL_DIGIT3 = 3'h2;
  localparam logic [2:0] FPI_SEL_BRIGHT = 3'h3;
  localparam logic [2:0] FPI_SEL_CTRL = 3'h4;
  localparam logic [2:0] FPI_SEL_IRQ = 3'h5;
  localparam logic [2:0] FPI_SEL_SHADOW = 3'h6;
  localparam logic [2:0] FPI_SEL_KEY = 3'h7;
  // control latch fields
  localparam int FPI_CTL_MET0 = 0;
  localparam int FPI_CTL_METER_SELECT_1 = 1;
  localparam int FPI_CTL_AUDIO = 2;
  localparam int FPI_CTL_RECALL = 3;
  localparam int FPI_CTL_STORE = 4;
  localparam int FPI_CTL_ENCDIR = 5;
  localparam logic [7:0] FPI_CTL_RESET = 8'h00;
  // bright latch fields: group index in [2:0], enable in bit 3
  localparam int FPI_BRT_EN = 3;
  localparam logic [7:0] FPI_BRT_RESET = 8'h00;
  // interrupt status fields
  localparam int FPI_IST_KEY = 0;
  localparam int FPI_IST_ENC = 1;
  localparam int FPI_IST_SW = 2;
  localparam int FPI_IST_DIR = 3;
  localparam int FPI_IST_REMOTE = 4;
  // display timing, in milliseconds; one multiplex tick per slot
  localparam int FPI_SLOT_MS = 2;
  localparam int FPI_FRAME_MS = 16;
  localparam int FPI_BRIGHT_MS = 6;
  localparam int FPI_SLOTS = FPI_FRAME_MS / FPI_SLOT_MS;
  localparam int FPI_BRIGHT_SLOTS = FPI_BRIGHT_MS / FPI_SLOT_MS;
  localparam int FPI_GROUPS = 6;
  localparam int FPI_DIGITS = 3;
  localparam int FPI_SEGS = 8;
  localparam int FPI_SHADOW_AW = 6;
  localparam int FPI_SHADOW_DW = 4;
  localparam int FPI_KEY_W = 5;
  // display sweep states
  typedef enum logic [0:0] {
    FPI_SWEEP_NORMAL = 1'b0,
    FPI_SWEEP_BRIGHT = 1'b1
  } fpi_sweep_e;
endpackage : fpi_pkg

// >>> rtl/fpi_front_panel.sv
// front panel interface: bus latches, memories, interrupts, display multiplex
//
// Contract
// - switch grounded gives no switch interrupt; opening it signals remote mode.
// - low address byte is captured from the bus while the latch strobe is high.
// - channel memory uses latched low address plus bus bits 8 to 10.
// - keypad, knob or switch events request a processor interrupt.
// - processor reads the event source then acknowledges; acknowledge clears it.
// - shadow memory drives the bus only in the data phase.
// - shadow memory word address is latched bits 0 to 5; write enable low writes.
// - store and recall are two control latch bits; writes go to working array.
// - normal groups lit 2 ms, bright group 6 ms, per 16 ms frame.
// - at most one of six group selects is high; segments go to that group.
// - each digit has eight segment lines, A to G and decimal point.
// - read strobe low reads, write strobe low writes, select low means memory.
// - channel memory enable and port enable are active low; port gates decoder.
// - interrupt request and acknowledge are both active low.
// - audio mute is driven low to mute; two meter select bits.
// - decoder on bits 8 to 10 latches bus data at end of write strobe.
// - control bit presets encoder direction; encoder pulses set it and interrupt.
// - debounced key press sets pending flag; key code read on bits 0 to 4.
module fpi_front_panel
  import fpi_pkg::*;
#(
  parameter int CHAN_AW = 11
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] muxed_bus_in,
  output logic [7:0] muxed_bus_out,
  output logic muxed_bus_oe,
  input wire logic [2:0] addr_hi,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic io_m,
  input wire logic chan_mem_enable_n,
  input wire logic panel_port_enable_n,
  input wire logic irq_acknowledge_n,
  output logic irq_request_n,
  output logic remote_irq,
  input wire logic local_switch_n,
  input wire logic key_avail,
  input wire logic [FPI_KEY_W-1:0] key_code,
  input wire logic enc_pulse,
  input wire logic enc_up,
  input wire logic mux_tick,
  output logic audio_mute_n,
  output logic meter_select_0,
  output logic meter_select_1,
  output logic digit_group_select_1,
  output logic digit_group_select_2,
  output logic digit_group_select_3,
  output logic digit_group_select_4,
  output logic digit_group_select_5,
  output logic digit_group_select_6,
  output logic [6:0] seg_digit_1,
  output logic [6:0] seg_digit_2,
  output logic [6:0] seg_digit_3,
  output logic decimal_point_seg_1,
  output logic decimal_point_seg_2,
  output logic decimal_point_seg_3
);

  logic [7:0] low_addr_r;
  logic wr_n_prev_r;
  logic [7:0] wdata_r;
  logic [2:0] whi_r;
  logic w_chan_r;
  logic w_io_r;
  logic commit;
  logic [7:0] ctrl_r;
  logic [7:0] bright_r;
  logic [7:0] seg_mem_r [FPI_GROUPS*FPI_DIGITS];
  logic [7:0] chan_mem_r [2**CHAN_AW];
  logic [FPI_SHADOW_DW-1:0] work_mem_r [2**FPI_SHADOW_AW];
  logic [FPI_SHADOW_DW-1:0] nv_mem_r [2**FPI_SHADOW_AW];
  logic key_pend_r;
  logic enc_pend_r;
  logic sw_pend_r;
  logic enc_dir_r;
  logic remote_r;
  logic [FPI_KEY_W-1:0] key_r;
  logic [2:0] seen_r;
  logic ack_prev_r;
  logic ack_fall;
  logic rd_io;
  logic rd_chan;
  logic [7:0] rd_nxt;
  logic rd_hit;
  logic [2:0] slot_r;
  fpi_sweep_e sweep_r;
  logic [5:0] grp_r;
  logic [7:0] seg_r [FPI_DIGITS];
  logic [2:0] cur_grp;
  logic cur_on;

  // address phase: low byte held from the latch strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_addr_r <= 8'h00;
    end else if (ale) begin
      low_addr_r <= muxed_bus_in;
    end
  end

  // write cycle capture; data is sampled while the strobe is low and committed at its rising edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_n_prev_r <= 1'b1;
      wdata_r <= 8'h00;
      whi_r <= 3'h0;
      w_chan_r <= 1'b0;
      w_io_r <= 1'b0;
    end else begin
      wr_n_prev_r <= wr_n;
      if (!wr_n && !ale) begin
        wdata_r <= muxed_bus_in;
        whi_r <= addr_hi;
        w_chan_r <= !io_m && !chan_mem_enable_n;
        w_io_r <= io_m && !panel_port_enable_n;
      end
    end
  end
  assign commit = wr_n && !wr_n_prev_r;

  // control and bright latches
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= FPI_CTL_RESET;
      bright_r <= FPI_BRT_RESET;
    end else if (commit && w_io_r) begin
      if (whi_r == FPI_SEL_CTRL) begin
        ctrl_r <= wdata_r;
      end
      if (whi_r == FPI_SEL_BRIGHT) begin
        bright_r <= wdata_r;
      end
    end
  end

  // segment latches: decoder code picks digit, low address picks group
  generate
    for (genvar i = 0; i < FPI_GROUPS * FPI_DIGITS; i++) begin : g_seg
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          seg_mem_r[i] <= 8'h00;
        end else if (commit && w_io_r && whi_r == 3'(i % FPI_DIGITS)
                     && low_addr_r[2:0] == 3'(i / FPI_DIGITS)) begin
          seg_mem_r[i] <= wdata_r;
        end
      end
    end
  endgenerate

  // channel memory, no reset: contents are data, not control
  always_ff @(posedge clk_sys) begin
    if (commit && w_chan_r) begin
      chan_mem_r[{whi_r, low_addr_r}] <= wdata_r;
    end
  end

  // shadow memory: writes hit the working array; store and recall move whole
  // arrays in one cycle on the rising edge of their control bits
  always_ff @(posedge clk_sys) begin
    if (commit && w_io_r && whi_r == FPI_SEL_CTRL && wdata_r[FPI_CTL_STORE]
        && !ctrl_r[FPI_CTL_STORE]) begin
      nv_mem_r <= work_mem_r;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (commit && w_io_r && whi_r == FPI_SEL_CTRL && wdata_r[FPI_CTL_RECALL]
        && !ctrl_r[FPI_CTL_RECALL]) begin
      work_mem_r <= nv_mem_r;
    end else if (commit && w_io_r && whi_r == FPI_SEL_SHADOW) begin
      work_mem_r[low_addr_r[FPI_SHADOW_AW-1:0]] <= wdata_r[FPI_SHADOW_DW-1:0];
    end
  end

  // acknowledge edge; only sources seen by the status read are cleared
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_prev_r <= 1'b1;
    end else begin
      ack_prev_r <= irq_acknowledge_n;
    end
  end
  assign ack_fall = !irq_acknowledge_n && ack_prev_r;

  // event flags; a new event in the acknowledge cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      key_pend_r <= 1'b0;
      enc_pend_r <= 1'b0;
      sw_pend_r <= 1'b0;
      key_r <= '0;
    end else begin
      if (key_avail) begin
        key_pend_r <= 1'b1;
        key_r <= key_code;
      end else if (ack_fall && seen_r[FPI_IST_KEY]) begin
        key_pend_r <= 1'b0;
      end
      if (enc_pulse) begin
        enc_pend_r <= 1'b1;
      end else if (ack_fall && seen_r[FPI_IST_ENC]) begin
        enc_pend_r <= 1'b0;
      end
      if (local_switch_n && !remote_r) begin
        sw_pend_r <= 1'b1;
      end else if (ack_fall && seen_r[FPI_IST_SW]) begin
        sw_pend_r <= 1'b0;
      end
    end
  end

  // local/remote state: only the open-going edge raises an event
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      remote_r <= 1'b0;
    end else begin
      remote_r <= local_switch_n;
    end
  end

  // encoder direction: preset from control, then follows each pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enc_dir_r <= 1'b0;
    end else if (enc_pulse) begin
      enc_dir_r <= enc_up;
    end else if (commit && w_io_r && whi_r == FPI_SEL_CTRL) begin
      enc_dir_r <= wdata_r[FPI_CTL_ENCDIR];
    end
  end

  // interrupt request outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_request_n <= 1'b1;
      remote_irq <= 1'b0;
    end else begin
      irq_request_n <= !(key_pend_r || enc_pend_r || sw_pend_r);
      remote_irq <= sw_pend_r;
    end
  end

  // read decode, data phase only: never while the latch strobe is high
  assign rd_io = !rd_n && !ale && io_m && !panel_port_enable_n;
  assign rd_chan = !rd_n && !ale && !io_m && !chan_mem_enable_n;
  always_comb begin
    rd_nxt = 8'h00;
    rd_hit = 1'b0;
    if (rd_chan) begin
      rd_nxt = chan_mem_r[{addr_hi, low_addr_r}];
      rd_hit = 1'b1;
    end else if (rd_io) begin
      rd_hit = 1'b1;
      unique case (addr_hi)
        FPI_SEL_IRQ: begin
          rd_nxt[FPI_IST_KEY] = key_pend_r;
          rd_nxt[FPI_IST_ENC] = enc_pend_r;
          rd_nxt[FPI_IST_SW] = sw_pend_r;
          rd_nxt[FPI_IST_DIR] = enc_dir_r;
          rd_nxt[FPI_IST_REMOTE] = remote_r;
        end
        FPI_SEL_KEY: rd_nxt[FPI_KEY_W-1:0] = key_r;
        FPI_SEL_SHADOW: rd_nxt[FPI_SHADOW_DW-1:0] =
          work_mem_r[low_addr_r[FPI_SHADOW_AW-1:0]];
        FPI_SEL_CTRL: rd_nxt = ctrl_r;
        FPI_SEL_BRIGHT: rd_nxt = bright_r;
        default: rd_hit = 1'b0; // write-only digit latches
      endcase
    end
  end

  // bus driver; snapshot of sources seen by a status read for the acknowledge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      muxed_bus_out <= 8'h00;
      muxed_bus_oe <= 1'b0;
      seen_r <= 3'h0;
    end else begin
      muxed_bus_out <= rd_nxt;
      muxed_bus_oe <= rd_hit;
      if (rd_io && addr_hi == FPI_SEL_IRQ) begin
        seen_r <= rd_nxt[2:0];
      end
    end
  end

  // control outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      audio_mute_n <= FPI_CTL_RESET[FPI_CTL_AUDIO];
      meter_select_0 <= FPI_CTL_RESET[FPI_CTL_MET0];
      meter_select_1 <= FPI_CTL_RESET[FPI_CTL_METER_SELECT_1];
    end else begin
      audio_mute_n <= ctrl_r[FPI_CTL_AUDIO];
      meter_select_0 <= ctrl_r[FPI_CTL_MET0];
      meter_select_1 <= ctrl_r[FPI_CTL_METER_SELECT_1];
    end
  end

  // multiplex sweep: six normal slots, then the bright group's extra slots;
  // with brightening off those slots stay dark so normal duty never changes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slot_r <= 3'h0;
      sweep_r <= FPI_SWEEP_NORMAL;
    end else if (mux_tick) begin
      slot_r <= slot_r + 3'h1; // wraps after FPI_SLOTS ticks
      unique case (sweep_r)
        FPI_SWEEP_NORMAL: if (slot_r == 3'(FPI_GROUPS - 1)) sweep_r <= FPI_SWEEP_BRIGHT;
        FPI_SWEEP_BRIGHT: if (slot_r == 3'(FPI_SLOTS - 1)) sweep_r <= FPI_SWEEP_NORMAL;
      endcase
    end
  end

  // group currently owed light; bright group gets its own slot plus two
  always_comb begin
    cur_grp = slot_r;
    cur_on = 1'b1;
    if (sweep_r == FPI_SWEEP_BRIGHT) begin
      cur_grp = bright_r[2:0];
      cur_on = bright_r[FPI_BRT_EN] && bright_r[2:0] < 3'(FPI_GROUPS);
    end
  end

  // one-hot group select and the segments of that group only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      grp_r <= 6'h00;
    end else begin
      grp_r <= cur_on ? 6'(6'h01 << cur_grp) : 6'h00;
    end
  end
  generate
    for (genvar d = 0; d < FPI_DIGITS; d++) begin : g_dig
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          seg_r[d] <= 8'h00;
        end else begin
          seg_r[d] <= cur_on ? seg_mem_r[32'(cur_grp) * FPI_DIGITS + d] : 8'h00;
        end
      end
    end
  endgenerate

  assign digit_group_select_1 = grp_r[0];
  assign digit_group_select_2 = grp_r[1];
  assign digit_group_select_3 = grp_r[2];
  assign digit_group_select_4 = grp_r[3];
  assign digit_group_select_5 = grp_r[4];
  assign digit_group_select_6 = grp_r[5];
  // segment A in bit 0 through G in bit 6, decimal point in bit 7
  assign seg_digit_1 = seg_r[0][6:0];
  assign seg_digit_2 = seg_r[1][6:0];
  assign seg_digit_3 = seg_r[2][6:0];
  assign decimal_point_seg_1 = seg_r[0][7];
  assign decimal_point_seg_2 = seg_r[1][7];
  assign decimal_point_seg_3 = seg_r[2][7];

endmodule // fpi_front_panel

// >>> bench/fpi_front_panel_asserts.sv
// checker: bus, interrupt and display relations at the front panel ports
module fpi_front_panel_asserts (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic chan_mem_enable_n,
  input wire logic panel_port_enable_n,
  input wire logic irq_acknowledge_n,
  input wire logic irq_request_n,
  input wire logic remote_irq,
  input wire logic local_switch_n,
  input wire logic key_avail,
  input wire logic enc_pulse,
  input wire logic muxed_bus_oe,
  input wire logic digit_group_select_1,
  input wire logic digit_group_select_2,
  input wire logic digit_group_select_3,
  input wire logic digit_group_select_4,
  input wire logic digit_group_select_5,
  input wire logic digit_group_select_6
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_one_group: assert property ($onehot0({digit_group_select_1, digit_group_select_2,
    digit_group_select_3, digit_group_select_4, digit_group_select_5, digit_group_select_6}))
    else $error("more than one digit group lit");
  chk_event_irq: assert property ((key_avail || enc_pulse) && irq_acknowledge_n
    ##1 irq_acknowledge_n |=> !irq_request_n) else $error("event raised no request");
  chk_local_quiet: assert property (!local_switch_n [*3] |-> !$rose(remote_irq))
    else $error("switch event while local");
  chk_remote_event: assert property ($rose(local_switch_n) && irq_acknowledge_n
    |-> ##[1:3] remote_irq) else $error("switch opening not signalled");
  chk_oe_phase: assert property (muxed_bus_oe |-> $past(!ale && !rd_n))
    else $error("bus driven outside data phase");
  chk_oe_release: assert property ($rose(rd_n) |=> !muxed_bus_oe)
    else $error("bus held after read strobe");
  chk_no_enable: assert property (chan_mem_enable_n && panel_port_enable_n
    |=> !muxed_bus_oe) else $error("bus driven without enable");
  chk_ack_release: assert property ($rose(irq_request_n) |-> !$past(irq_acknowledge_n, 2))
    else $error("request dropped without acknowledge");
endmodule // fpi_front_panel_asserts

bind fpi_front_panel fpi_front_panel_asserts fpi_front_panel_asserts_inst (.clk_sys, .srst,
  .ale, .rd_n, .chan_mem_enable_n, .panel_port_enable_n, .irq_acknowledge_n, .irq_request_n,
  .remote_irq, .local_switch_n, .key_avail, .enc_pulse, .muxed_bus_oe, .digit_group_select_1,
  .digit_group_select_2, .digit_group_select_3, .digit_group_select_4, .digit_group_select_5,
  .digit_group_select_6);

// >>> bench/fpi_cpu.sv
// partner: processor side of the multiplexed bus, with acknowledge
module fpi_cpu (
  input wire logic clk_sys,
  input wire logic [7:0] bus_rd,
  input wire logic bus_oe,
  output logic [7:0] bus_drv,
  output logic [2:0] addr_hi,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic io_m,
  output logic chan_mem_enable_n,
  output logic panel_port_enable_n,
  output logic irq_acknowledge_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus levels before any request
  initial begin
    {bus_drv, addr_hi} = 11'h000;
    {ale, rd_n, wr_n, io_m, chan_mem_enable_n, panel_port_enable_n} = 6'h1F;
    irq_acknowledge_n = 1'b1;
  end
  // address phase: low byte under the latch strobe, enable picked by space
  task automatic adr(input logic io, input logic [7:0] lo);
    @(posedge clk_sys);
    ale <= 1'b1;
    bus_drv <= lo;
    io_m <= io;
    chan_mem_enable_n <= io;
    panel_port_enable_n <= !io;
    @(posedge clk_sys);
    ale <= 1'b0;
  endtask
  task automatic wr(input logic io, input logic [2:0] hi, input logic [7:0] lo, d);
    adr(io, lo);
    addr_hi <= hi;
    bus_drv <= d;
    wr_n <= 1'b0;
    @(posedge clk_sys);
    wr_n <= 1'b1;
    @(posedge clk_sys);
    {chan_mem_enable_n, panel_port_enable_n} <= 2'h3;
    bus_drv <= ~d; // released lines do not keep the last value
  endtask
  task automatic rd(input logic io, input logic [2:0] hi, input logic [7:0] lo,
    output logic [7:0] d);
    int n;
    adr(io, lo);
    addr_hi <= hi;
    rd_n <= 1'b0;
    bus_drv <= ~lo;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (bus_oe !== 1'b1 && n < 6);
    d = bus_rd;
    rd_n <= 1'b1;
    {chan_mem_enable_n, panel_port_enable_n} <= 2'h3;
  endtask
  // acknowledge only after the status read, held low one cycle
  task automatic ack();
    @(posedge clk_sys);
    irq_acknowledge_n <= 1'b0;
    @(posedge clk_sys);
    irq_acknowledge_n <= 1'b1;
  endtask
endmodule // fpi_cpu

// >>> bench/fpi_front_panel_tb.sv
// testbench: bus, memories, interrupts and display multiplex of the panel
module fpi_front_panel_tb;
  import fpi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, srst = 1'b1, ale, rd_n, wr_n, io_m, chan_mem_enable_n;
  logic panel_port_enable_n, irq_acknowledge_n, irq_request_n, remote_irq, muxed_bus_oe;
  logic local_switch_n = 1'b0, key_avail = 1'b0, enc_pulse = 1'b0, enc_up = 1'b0;
  logic mux_tick = 1'b0, audio_mute_n, meter_select_0, meter_select_1;
  logic [FPI_KEY_W-1:0] key_code = 5'h00;
  logic [7:0] muxed_bus_out, cpu_drv, d;
  logic [2:0] addr_hi, dp;
  logic [6:1] dg;
  logic [6:0] seg_1, seg_2, seg_3;
  int num_errors = 0, n_checks = 0;
  // the wire level follows whoever has the bus enabled
  wire [7:0] bus_w = muxed_bus_oe ? muxed_bus_out : cpu_drv;
  fpi_front_panel fpi_front_panel_inst (.clk_sys, .srst, .muxed_bus_in(bus_w), .muxed_bus_out,
    .muxed_bus_oe, .addr_hi, .ale, .rd_n, .wr_n, .io_m, .chan_mem_enable_n,
    .panel_port_enable_n, .irq_acknowledge_n, .irq_request_n, .remote_irq, .local_switch_n,
    .key_avail, .key_code, .enc_pulse, .enc_up, .mux_tick, .audio_mute_n, .meter_select_0,
    .meter_select_1, .digit_group_select_1(dg[1]), .digit_group_select_2(dg[2]),
    .digit_group_select_3(dg[3]), .digit_group_select_4(dg[4]), .digit_group_select_5(dg[5]),
    .digit_group_select_6(dg[6]), .seg_digit_1(seg_1), .seg_digit_2(seg_2),
    .seg_digit_3(seg_3), .decimal_point_seg_1(dp[0]), .decimal_point_seg_2(dp[1]),
    .decimal_point_seg_3(dp[2]));
  fpi_cpu fpi_cpu_inst (.clk_sys, .bus_rd(bus_w), .bus_oe(muxed_bus_oe), .bus_drv(cpu_drv),
    .addr_hi, .ale, .rd_n, .wr_n, .io_m, .chan_mem_enable_n, .panel_port_enable_n,
    .irq_acknowledge_n);
  always #20 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // wait for the request, read the source, acknowledge, see it drop
  task automatic irq_round(input logic [7:0] st);
    for (int n = 0; n < 8 && irq_request_n !== 1'b0; n++) @(posedge clk_sys);
    chk(8'(irq_request_n), 8'h00, "request low");
    fpi_cpu_inst.rd(1'b1, FPI_SEL_IRQ, 8'h00, d);
    chk(d, st, "status");
    fpi_cpu_inst.ack();
    repeat (3) @(posedge clk_sys);
    chk(8'(irq_request_n), 8'h01, "request cleared");
  endtask
  task automatic t_ctrl();
    fpi_cpu_inst.wr(1'b1, FPI_SEL_CTRL, 8'h00, 8'h05);
    repeat (2) @(posedge clk_sys);
    chk(8'({audio_mute_n, meter_select_1, meter_select_0}), 8'h05, "ctrl out");
    fpi_cpu_inst.rd(1'b1, FPI_SEL_CTRL, 8'h00, d);
    chk(d, 8'h05, "ctrl read");
    // digit latches are write-only, so the block must leave the bus to the processor
    fpi_cpu_inst.rd(1'b1, FPI_SEL_DIGIT1, 8'h00, d);
    chk(8'(muxed_bus_oe), 8'h00, "digit read refused");
    $display("control test done");
  endtask
  // same low byte, two high codes: high bits must come from the bus
  task automatic t_chan();
    fpi_cpu_inst.wr(1'b0, 3'h5, 8'hA3, 8'h3C);
    fpi_cpu_inst.wr(1'b0, 3'h2, 8'hA3, 8'hC3);
    fpi_cpu_inst.rd(1'b0, 3'h5, 8'hA3, d);
    chk(d, 8'h3C, "chan hi 5");
    fpi_cpu_inst.rd(1'b0, 3'h2, 8'hA3, d);
    chk(d, 8'hC3, "chan hi 2");
    $display("channel memory test done");
  endtask
  // store 9, overwrite with 3, recall brings 9 back; word aliases on bits 0 to 5
  task automatic t_shadow();
    fpi_cpu_inst.wr(1'b1, FPI_SEL_SHADOW, 8'h2A, 8'h09);
    fpi_cpu_inst.wr(1'b1, FPI_SEL_CTRL, 8'h00, 8'h10);
    fpi_cpu_inst.wr(1'b1, FPI_SEL_SHADOW, 8'h2A, 8'h03);
    fpi_cpu_inst.rd(1'b1, FPI_SEL_SHADOW, 8'h2A, d);
    chk(d, 8'h03, "working copy");
    fpi_cpu_inst.wr(1'b1, FPI_SEL_CTRL, 8'h00, 8'h08);
    fpi_cpu_inst.rd(1'b1, FPI_SEL_SHADOW, 8'hEA, d);
    chk(d, 8'h09, "recalled word");
    $display("shadow memory test done");
  endtask
  task automatic t_events();
    @(posedge clk_sys);
    {key_avail, key_code} <= 6'h33;
    @(posedge clk_sys);
    key_avail <= 1'b0;
    irq_round(8'h01);
    fpi_cpu_inst.rd(1'b1, FPI_SEL_KEY, 8'h00, d);
    chk(d, 8'h13, "key code");
    {enc_pulse, enc_up} <= 2'h3;
    @(posedge clk_sys);
    enc_pulse <= 1'b0;
    irq_round(8'h0A);
    repeat (10) @(posedge clk_sys);
    chk(8'({remote_irq, irq_request_n}), 8'h01, "local quiet");
    local_switch_n <= 1'b1; // processor now ignores keys
    repeat (4) @(posedge clk_sys);
    chk(8'(remote_irq), 8'h01, "remote raised");
    irq_round(8'h1C);
    chk(8'(remote_irq), 8'h00, "remote cleared");
    $display("interrupt test done");
  endtask
  // one frame of eight ticks with group 3 intensified; group 1 and group 3 hold
  // distinct patterns so segments steered to the wrong group show up
  task automatic t_display();
    int cnt[6:1];
    cnt = '{default: 0};
    fpi_cpu_inst.wr(1'b1, FPI_SEL_DIGIT1, 8'h00, 8'hA5);
    fpi_cpu_inst.wr(1'b1, FPI_SEL_DIGIT2, 8'h00, 8'h5A);
    fpi_cpu_inst.wr(1'b1, FPI_SEL_DIGIT3, 8'h00, 8'h81);
    fpi_cpu_inst.wr(1'b1, FPI_SEL_DIGIT1, 8'h02, 8'h3C);
    fpi_cpu_inst.wr(1'b1, FPI_SEL_BRIGHT, 8'h00, 8'h0A);
    fpi_cpu_inst.rd(1'b1, FPI_SEL_BRIGHT, 8'h00, d);
    chk(d, 8'h0A, "bright read");
    repeat (8) begin
      mux_tick <= 1'b1;
      @(posedge clk_sys);
      mux_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int g = 1; g <= 6; g++) cnt[g] += dg[g];
      if (dg[1] === 1'b1) begin
        chk({dp[0], seg_1}, 8'hA5, "group 1 digit 1");
        chk({dp[1], seg_2}, 8'h5A, "group 1 digit 2");
        chk({dp[2], seg_3}, 8'h81, "group 1 digit 3");
      end
      if (dg[3] === 1'b1) chk({dp[0], seg_1}, 8'h3C, "group 3 digit 1");
    end
    for (int g = 1; g <= 6; g++) chk(8'(cnt[g]), (g == 3) ? 8'(FPI_BRIGHT_SLOTS) : 8'h01, "slots");
    $display("display test done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    // still in reset: idle bus, no request, muted, display dark
    chk({irq_request_n, remote_irq, audio_mute_n, muxed_bus_oe, 4'h0}, 8'h80, "reset");
    chk(8'(dg), 8'h00, "reset groups");
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // slot 0 lights group 1 at the first edge out of reset, before any tick
    chk({irq_request_n, remote_irq, audio_mute_n, muxed_bus_oe, 4'h0}, 8'h80, "released");
    chk(8'(dg), 8'h01, "group 1 after reset");
    t_ctrl();
    t_chan();
    t_shadow();
    t_events();
    t_display();
    stop_test();
  end
  // watchdog well past the expected run of a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end
endmodule // fpi_front_panel_tb
